/* inc/t16cc_pkg.sv */
// Package for the 16-bit capture/compare timer: map, fields, resets, timing.
package t16cc_pkg;

    // Register word indices; byte address is index times four
    localparam logic [5:0] T16CC_IDX_CTRL_A = 6'h00;
    localparam logic [5:0] T16CC_IDX_CTRL_B = 6'h01;
    localparam logic [5:0] T16CC_IDX_STATUS = 6'h02;
    localparam logic [5:0] T16CC_IDX_CAP1_HI = 6'h03;
    localparam logic [5:0] T16CC_IDX_CAP1_LO = 6'h04;
    localparam logic [5:0] T16CC_IDX_CMP1_HI = 6'h05;
    localparam logic [5:0] T16CC_IDX_CMP1_LO = 6'h06;
    localparam logic [5:0] T16CC_IDX_CNT_HI = 6'h07;
    localparam logic [5:0] T16CC_IDX_CNT_LO = 6'h08;
    localparam logic [5:0] T16CC_IDX_SHD_HI = 6'h09;
    localparam logic [5:0] T16CC_IDX_SHD_LO = 6'h0A;
    localparam logic [5:0] T16CC_IDX_CAP2_HI = 6'h0B;
    localparam logic [5:0] T16CC_IDX_CAP2_LO = 6'h0C;
    localparam logic [5:0] T16CC_IDX_CMP2_HI = 6'h0D;
    localparam logic [5:0] T16CC_IDX_CMP2_LO = 6'h0E;
    localparam logic [5:0] T16CC_IDX_MISC = 6'h0F;

    // Reset and reload values
    localparam logic [15:0] T16CC_CNT_RESET = 16'hFFFC;
    localparam logic [15:0] T16CC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] T16CC_CMP_RESET = 16'h8000;

    // Clock select encodings
    localparam logic [1:0] T16CC_CS_DIV4 = 2'h0;
    localparam logic [1:0] T16CC_CS_DIV2 = 2'h1;
    localparam logic [1:0] T16CC_CS_DIV8 = 2'h2;
    localparam logic [1:0] T16CC_CS_EXT = 2'h3;

    // Prescaler masks: tick when the low bits of the divider are all ones
    localparam logic [2:0] T16CC_MASK_DIV2 = 3'h1;
    localparam logic [2:0] T16CC_MASK_DIV4 = 3'h3;
    localparam logic [2:0] T16CC_MASK_DIV8 = 3'h7;

    // Status bit positions
    localparam int T16CC_ST_ICF1 = 7;
    localparam int T16CC_ST_OCF1 = 6;
    localparam int T16CC_ST_TOF = 5;
    localparam int T16CC_ST_ICF2 = 4;
    localparam int T16CC_ST_OCF2 = 3;

    // AXI responses
    localparam logic [1:0] T16CC_RESP_OKAY = 2'h0;
    localparam logic [1:0] T16CC_RESP_SLVERR = 2'h2;

    // Control register A layout, reset 00
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_level_2;
        logic force_level_1;
        logic compare_level_2;
        logic capture_edge_1;
        logic compare_level_1;
    } t16cc_ctrl_a_t;

    // Control register B layout, reset 00
    typedef struct packed {
        logic compare_out_enable_1;
        logic compare_out_enable_2;
        logic one_pulse_select;
        logic pwm_select;
        logic [1:0] clock_select;
        logic capture_edge_2;
        logic ext_edge_select;
    } t16cc_ctrl_b_t;

    localparam logic [7:0] T16CC_CTRL_RESET = 8'h00;

endpackage : t16cc_pkg

/* src/t16cc_top.sv */
// 16-bit free-running timer with two captures, two compares and an AXI4-Lite slave.
// What this block does
// - Reading counter high byte latches low byte until low byte is read.
// - After a full read pair, a lone low read returns the live low byte.
// - Overflow flag sets when the counter wraps FFFF to 0000, any mode.
// - Overflow interrupt needs overflow enable set and core mask clear; otherwise pending.
// - Overflow flag clears by status read while set, then count_low_byte access.
// - Shadow low access never clears overflow; shadow reads same counter value.
// - Counter runs in wait; stops in halt, resumes held count or reset count.
// - Clock select both ones picks external pin; edge select picks its transition.
// - Counter synchronised to CPU clock; external edges at least four clocks apart.
// - Internal timer clock is CPU clock divided by 2, 4 or 8.
// - Active capture pin edge copies counter into capture value; edge bit selects polarity.
// - Capture sets its flag; interrupt with capture enable and core mask clear.
// - Capture flag clears by status read while set, then capture low access.
// - After capture high read, no capture update or flag until capture low read.
// - Capture pins always feed capture logic; registers hold the latest capture.
// - In one-pulse and pulse-width modes only capture channel two captures.
// - Compare registers reset to 8000h, software read/write, untouched by hardware.
// - Match sets compare flag; enabled pin takes level; pin latch low in reset.
// - Flag and pin update asserted while counter equals compare, all clocks; compare 1 off in special modes, both off in pulse-width mode.
// - Compare high write inhibits that channel until compare low is written.
// - Compare flag clear by status read then low access; interrupt needs enable, mask clear.
// - With output disabled the pin gets no level, interrupt may still occur.
// - Counter resets to FFFCh; count or shadow low write reloads FFFCh.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module t16cc_top
    import t16cc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // AXI4-Lite write address and data
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic [2:0] i_s_axi_awprot,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // AXI4-Lite read
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input wire logic [2:0] i_s_axi_arprot,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // Power state from the system
    input wire logic i_halt,
    // Timer pins
    input wire logic i_ext_clock_pin,
    input wire logic [1:0] i_capture_pin,
    output logic [1:0] o_compare_pin,
    output logic [1:0] o_compare_pin_oe,
    // Timer interrupt
    output logic o_timer_irq
);

    // Decode of a mapped word index
    function automatic logic t16cc_mapped(input logic [5:0] idx);
        t16cc_mapped = (idx <= T16CC_IDX_MISC);
    endfunction : t16cc_mapped

    // Register state
    t16cc_ctrl_a_t ctrl_a_r;
    t16cc_ctrl_b_t ctrl_b_r;
    logic core_mask_r;
    logic [15:0] count_r;
    logic [2:0] div_r;
    logic ext_prev_r;
    logic [1:0] cap_prev_r;
    logic [15:0] cap_val_r [2];
    logic [15:0] cmp_val_r [2];
    logic [1:0] cap_inhibit_r;
    logic [1:0] cmp_inhibit_r;
    logic [1:0] cap_flag_r;
    logic [1:0] cmp_flag_r;
    logic [1:0] cap_arm_r;
    logic [1:0] cmp_arm_r;
    logic tof_r;
    logic tof_arm_r;
    logic [7:0] cnt_buf_r;
    logic cnt_buf_full_r;
    logic [7:0] shd_buf_r;
    logic shd_buf_full_r;
    logic [1:0] pin_r;

    // Bus state
    logic aw_got_r;
    logic w_got_r;
    logic [5:0] wr_idx_r;
    logic [7:0] wr_data_r;
    logic wr_en_r;

    // Handshakes and access strobes
    logic hs_aw;
    logic hs_w;
    logic hs_ar;
    logic commit;
    logic [5:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic aw_got_nxt;
    logic w_got_nxt;

    assign hs_aw = i_s_axi_awvalid & o_s_axi_awready;
    assign hs_w = i_s_axi_wvalid & o_s_axi_wready;
    assign hs_ar = i_s_axi_arvalid & o_s_axi_arready;
    assign commit = aw_got_r & w_got_r & ~o_s_axi_bvalid;
    assign rd_idx = i_s_axi_araddr[7:2];
    assign rd_ok = t16cc_mapped(rd_idx);
    assign aw_got_nxt = (aw_got_r | hs_aw) & ~commit;
    assign w_got_nxt = (w_got_r | hs_w) & ~commit;

    // Per-register read and write strobes
    function automatic logic rd_at(input logic [5:0] idx);
        rd_at = hs_ar & (rd_idx == idx);
    endfunction : rd_at

    function automatic logic wr_at(input logic [5:0] idx);
        wr_at = commit & wr_en_r & (wr_idx_r == idx);
    endfunction : wr_at

    // Either direction of access to a low byte counts for flag clearing
    function automatic logic acc_at(input logic [5:0] idx);
        acc_at = rd_at(idx) | wr_at(idx);
    endfunction : acc_at

    // Write address and data may arrive in either order
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_idx_r <= 6'h00;
            wr_data_r <= 8'h00;
            wr_en_r <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            o_s_axi_awready <= ~aw_got_nxt;
            o_s_axi_wready <= ~w_got_nxt;
            if (hs_aw) begin
                wr_idx_r <= i_s_axi_awaddr[7:2];
            end
            if (hs_w) begin
                wr_data_r <= i_s_axi_wdata[7:0];
                wr_en_r <= i_s_axi_wstrb[0];
            end
        end
    end

    // Write response follows the commit; one write outstanding
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= T16CC_RESP_OKAY;
        end else if (commit) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= t16cc_mapped(wr_idx_r) ? T16CC_RESP_OKAY : T16CC_RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux; side effects of reads are taken at the address handshake
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_idx)
            T16CC_IDX_CTRL_A: rd_byte = ctrl_a_r;
            T16CC_IDX_CTRL_B: rd_byte = ctrl_b_r;
            T16CC_IDX_STATUS: rd_byte = {cap_flag_r[0], cmp_flag_r[0], tof_r,
                                         cap_flag_r[1], cmp_flag_r[1], 3'h0};
            T16CC_IDX_CAP1_HI: rd_byte = cap_val_r[0][15:8];
            T16CC_IDX_CAP1_LO: rd_byte = cap_val_r[0][7:0];
            T16CC_IDX_CMP1_HI: rd_byte = cmp_val_r[0][15:8];
            T16CC_IDX_CMP1_LO: rd_byte = cmp_val_r[0][7:0];
            T16CC_IDX_CNT_HI: rd_byte = count_r[15:8];
            T16CC_IDX_CNT_LO: rd_byte = cnt_buf_full_r ? cnt_buf_r : count_r[7:0];
            T16CC_IDX_SHD_HI: rd_byte = count_r[15:8];
            T16CC_IDX_SHD_LO: rd_byte = shd_buf_full_r ? shd_buf_r : count_r[7:0];
            T16CC_IDX_CAP2_HI: rd_byte = cap_val_r[1][15:8];
            T16CC_IDX_CAP2_LO: rd_byte = cap_val_r[1][7:0];
            T16CC_IDX_CMP2_HI: rd_byte = cmp_val_r[1][15:8];
            T16CC_IDX_CMP2_LO: rd_byte = cmp_val_r[1][7:0];
            T16CC_IDX_MISC: rd_byte = {7'h00, core_mask_r};
            default: rd_byte = 8'h00;
        endcase
    end

    // Read channel, one read outstanding
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= T16CC_RESP_OKAY;
        end else if (hs_ar) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= {24'h000000, rd_byte};
            o_s_axi_rresp <= rd_ok ? T16CC_RESP_OKAY : T16CC_RESP_SLVERR;
        end else if (o_s_axi_rvalid) begin
            o_s_axi_rvalid <= ~i_s_axi_rready;
            o_s_axi_arready <= i_s_axi_rready;
        end else begin
            o_s_axi_arready <= 1'b1;
        end
    end

    // Control registers; force bits act once and read back as zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_a_r <= T16CC_CTRL_RESET;
            ctrl_b_r <= T16CC_CTRL_RESET;
            core_mask_r <= 1'b0;
        end else begin
            if (wr_at(T16CC_IDX_CTRL_A)) begin
                ctrl_a_r <= wr_data_r;
            end else begin
                ctrl_a_r.force_level_1 <= 1'b0;
                ctrl_a_r.force_level_2 <= 1'b0;
            end
            if (wr_at(T16CC_IDX_CTRL_B)) begin
                ctrl_b_r <= wr_data_r;
            end
            if (wr_at(T16CC_IDX_MISC)) begin
                core_mask_r <= wr_data_r[0];
            end
        end
    end

    // Timer clock: prescaler or external edge, no tick while halted
    logic ext_edge;
    logic tick;
    logic [2:0] div_mask;
    logic special_mode;

    assign special_mode = ctrl_b_r.one_pulse_select | ctrl_b_r.pwm_select;
    // External pin taken as synchronous; edge spacing of four clocks is the source's duty
    assign ext_edge = (ext_prev_r != i_ext_clock_pin)
                      & (i_ext_clock_pin == ctrl_b_r.ext_edge_select);

    always_comb begin
        div_mask = T16CC_MASK_DIV4;
        unique case (ctrl_b_r.clock_select)
            T16CC_CS_DIV2: div_mask = T16CC_MASK_DIV2;
            T16CC_CS_DIV4: div_mask = T16CC_MASK_DIV4;
            T16CC_CS_DIV8: div_mask = T16CC_MASK_DIV8;
            T16CC_CS_EXT: div_mask = T16CC_MASK_DIV8;
        endcase
        if (i_halt) begin
            tick = 1'b0;
        end else if (ctrl_b_r.clock_select == T16CC_CS_EXT) begin
            tick = ext_edge;
        end else begin
            tick = ((div_r & div_mask) == div_mask);
        end
    end

    // Prescaler and pin history; the prescaler also freezes in halt
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_r <= 3'h0;
            ext_prev_r <= 1'b0;
            cap_prev_r <= 2'h0;
        end else begin
            if (!i_halt) begin
                div_r <= div_r + 3'h1;
            end
            ext_prev_r <= i_ext_clock_pin;
            cap_prev_r <= i_capture_pin;
        end
    end

    // Free-running counter; a low-byte write reloads the reset count
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_r <= T16CC_CNT_RESET;
        end else if (wr_at(T16CC_IDX_CNT_LO) || wr_at(T16CC_IDX_SHD_LO)) begin
            count_r <= T16CC_CNT_RESET;
        end else if (tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Low-byte buffers for the two-byte read sequence
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_buf_r <= 8'h00;
            cnt_buf_full_r <= 1'b0;
            shd_buf_r <= 8'h00;
            shd_buf_full_r <= 1'b0;
        end else begin
            // Repeat high reads keep the first latched value
            if (rd_at(T16CC_IDX_CNT_HI) && !cnt_buf_full_r) begin
                cnt_buf_r <= count_r[7:0];
                cnt_buf_full_r <= 1'b1;
            end else if (rd_at(T16CC_IDX_CNT_LO)) begin
                cnt_buf_full_r <= 1'b0;
            end
            if (rd_at(T16CC_IDX_SHD_HI) && !shd_buf_full_r) begin
                shd_buf_r <= count_r[7:0];
                shd_buf_full_r <= 1'b1;
            end else if (rd_at(T16CC_IDX_SHD_LO)) begin
                shd_buf_full_r <= 1'b0;
            end
        end
    end

    // Overflow flag: status read arms, count low access clears, set wins
    logic wrap;
    assign wrap = tick & (count_r == T16CC_CNT_MAX) & ~wr_at(T16CC_IDX_CNT_LO)
                  & ~wr_at(T16CC_IDX_SHD_LO);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tof_r <= 1'b0;
            tof_arm_r <= 1'b0;
        end else begin
            if (wrap) begin
                tof_r <= 1'b1;
            end else if (tof_arm_r && acc_at(T16CC_IDX_CNT_LO)) begin
                tof_r <= 1'b0;
            end
            if (rd_at(T16CC_IDX_STATUS)) begin
                tof_arm_r <= tof_r;
            end else if (acc_at(T16CC_IDX_CNT_LO)) begin
                tof_arm_r <= 1'b0;
            end
        end
    end

    // Capture and compare channels
    logic [1:0] cap_edge_sel;
    logic [1:0] cmp_level;
    logic [1:0] cmp_oe;
    logic [1:0] force_pulse;
    logic [1:0] cmp_allow;
    logic [1:0] cap_allow;

    assign cap_edge_sel = {ctrl_b_r.capture_edge_2, ctrl_a_r.capture_edge_1};
    assign cmp_level = {ctrl_a_r.compare_level_2, ctrl_a_r.compare_level_1};
    assign cmp_oe = {ctrl_b_r.compare_out_enable_2, ctrl_b_r.compare_out_enable_1};
    assign force_pulse = {ctrl_a_r.force_level_2, ctrl_a_r.force_level_1} & {2{~special_mode}};
    assign cap_allow = {1'b1, ~special_mode};
    // Mode sequencing owns the first compare in special modes, both in pulse-width mode
    assign cmp_allow = {~ctrl_b_r.pwm_select, ~special_mode};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            localparam logic [5:0] CAP_HI = (g == 0) ? T16CC_IDX_CAP1_HI : T16CC_IDX_CAP2_HI;
            localparam logic [5:0] CAP_LO = (g == 0) ? T16CC_IDX_CAP1_LO : T16CC_IDX_CAP2_LO;
            localparam logic [5:0] CMP_HI = (g == 0) ? T16CC_IDX_CMP1_HI : T16CC_IDX_CMP2_HI;
            localparam logic [5:0] CMP_LO = (g == 0) ? T16CC_IDX_CMP1_LO : T16CC_IDX_CMP2_LO;
            logic cap_evt;
            logic match;

            // Pin feeds capture even when driven as an output
            assign cap_evt = (cap_prev_r[g] != i_capture_pin[g])
                             & (i_capture_pin[g] == cap_edge_sel[g])
                             & ~cap_inhibit_r[g] & cap_allow[g];
            // Level match: asserted every cycle the counter sits on the value
            assign match = (count_r == cmp_val_r[g]) & ~cmp_inhibit_r[g];

            // Capture value and inhibit window
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    cap_val_r[g] <= 16'h0000;
                    cap_inhibit_r[g] <= 1'b0;
                end else begin
                    if (cap_evt) begin
                        cap_val_r[g] <= count_r;
                    end
                    if (rd_at(CAP_HI)) begin
                        cap_inhibit_r[g] <= 1'b1;
                    end else if (rd_at(CAP_LO)) begin
                        cap_inhibit_r[g] <= 1'b0;
                    end
                end
            end

            // Capture flag with two-step clear, set wins
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    cap_flag_r[g] <= 1'b0;
                    cap_arm_r[g] <= 1'b0;
                end else begin
                    if (cap_evt) begin
                        cap_flag_r[g] <= 1'b1;
                    end else if (cap_arm_r[g] && acc_at(CAP_LO)) begin
                        cap_flag_r[g] <= 1'b0;
                    end
                    if (rd_at(T16CC_IDX_STATUS)) begin
                        cap_arm_r[g] <= cap_flag_r[g];
                    end else if (acc_at(CAP_LO)) begin
                        cap_arm_r[g] <= 1'b0;
                    end
                end
            end

            // Compare value: only software writes it
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    cmp_val_r[g] <= T16CC_CMP_RESET;
                    cmp_inhibit_r[g] <= 1'b0;
                end else begin
                    if (wr_at(CMP_HI)) begin
                        cmp_val_r[g][15:8] <= wr_data_r;
                        cmp_inhibit_r[g] <= 1'b1;
                    end else if (wr_at(CMP_LO)) begin
                        cmp_val_r[g][7:0] <= wr_data_r;
                        cmp_inhibit_r[g] <= 1'b0;
                    end
                end
            end

            // Compare flag with two-step clear, set wins
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    cmp_flag_r[g] <= 1'b0;
                    cmp_arm_r[g] <= 1'b0;
                end else begin
                    if (match && cmp_allow[g]) begin
                        cmp_flag_r[g] <= 1'b1;
                    end else if (cmp_arm_r[g] && acc_at(CMP_LO)) begin
                        cmp_flag_r[g] <= 1'b0;
                    end
                    if (rd_at(T16CC_IDX_STATUS)) begin
                        cmp_arm_r[g] <= cmp_flag_r[g];
                    end else if (acc_at(CMP_LO)) begin
                        cmp_arm_r[g] <= 1'b0;
                    end
                end
            end

            // Pin latch: low in reset, takes level on match or force
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    pin_r[g] <= 1'b0;
                    o_compare_pin_oe[g] <= 1'b0;
                end else begin
                    o_compare_pin_oe[g] <= cmp_oe[g];
                    if ((match && cmp_allow[g] && cmp_oe[g]) || force_pulse[g]) begin
                        pin_r[g] <= cmp_level[g];
                    end
                end
            end
        end
    endgenerate

    assign o_compare_pin = pin_r;

    // Shared timer interrupt; a masked request stays pending in its flag
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_timer_irq <= 1'b0;
        end else begin
            o_timer_irq <= ~core_mask_r & ((tof_r & ctrl_a_r.overflow_irq_enable)
                           | (|cap_flag_r & ctrl_a_r.capture_irq_enable)
                           | (|cmp_flag_r & ctrl_a_r.compare_irq_enable));
        end
    end

endmodule : t16cc_top

/* testbench/t16cc_monitor.sv */
// Checker of the timer's bus answers and pin outputs.
`timescale 1ns/100ps
module t16cc_monitor (
    // Watched ports
    input wire logic i_clk, i_reset, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid,
    input wire logic o_s_axi_wready, o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid,
    input wire logic o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready, o_timer_irq,
    input wire logic [1:0] o_compare_pin, o_compare_pin_oe,
    input wire logic [31:0] o_s_axi_rdata
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Pins, enables and irq idle on the first edge after reset
    property p_rpin; $fell(i_reset) |-> o_compare_pin == 2'h0; endproperty
    a_rpin: assert property (p_rpin) else $error("pin not low");
    property p_roe; $fell(i_reset) |-> o_compare_pin_oe == 2'h0; endproperty
    a_roe: assert property (p_roe) else $error("oe not low");
    property p_rirq; $fell(i_reset) |-> !o_timer_irq; endproperty
    a_rirq: assert property (p_rirq) else $error("irq high");
    // One answer per request, held until taken
    property p_bdone; o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("bvalid repeated");
    property p_rhold; o_s_axi_rvalid && !i_s_axi_rready |=> $stable(o_s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("rdata moved");
    property p_rans; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("late read");
    property p_rref; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty
    a_rref: assert property (p_rref) else $error("arready in answer");
    property p_bans; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
        |-> ##[1:3] o_s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("late write");
endmodule : t16cc_monitor
bind t16cc_top t16cc_monitor i_t16cc_monitor (.*);

/* testbench/t16cc_pins.sv */
// Model of the external clock and capture sources.
`timescale 1ns/100ps
module t16cc_pins (
    input wire logic i_clk,
    output logic o_ext = 1'b0,
    output logic [1:0] o_cap = 2'h0
);
    // Rising edges eight clocks apart, so spacing never gets close
    task automatic ext_pulses(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge i_clk);
            o_ext <= ~o_ext;
        end
    endtask : ext_pulses
    // One pulse on the chosen capture pins
    task automatic cap_pulse(input logic [1:0] m);
        o_cap <= m;
        repeat (4) @(posedge i_clk);
        o_cap <= 2'h0;
    endtask : cap_pulse
endmodule : t16cc_pins

/* testbench/tb_top.sv */
// Self-checking bench for the capture/compare timer.
`timescale 1ns/100ps
module tb_top;
    import t16cc_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, i_halt = 1'b0, i_s_axi_awvalid = 1'b0;
    logic i_s_axi_wvalid = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic i_s_axi_bready = 1'b1, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic o_s_axi_arready, o_s_axi_rvalid, o_timer_irq, i_ext_clock_pin;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, rnd;
    logic [2:0] i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
    logic [1:0] i_capture_pin, o_compare_pin, o_compare_pin_oe, o_s_axi_bresp, o_s_axi_rresp;
    logic [33:0] exp_q[$];
    integer seed = 32'hB7FCF96D;
    int fail_count = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    t16cc_top i_t16cc_top (.*);
    t16cc_pins i_t16cc_pins (.i_clk(i_clk), .o_ext(i_ext_clock_pin), .o_cap(i_capture_pin));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [33:0] ok(input logic [7:0] b);
        return {T16CC_RESP_OKAY, 24'h0, b};
    endfunction : ok
    // Byte write, each half released once taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        i_s_axi_awaddr <= {idx, 2'h0};
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (i_s_axi_awvalid || i_s_axi_wvalid);
        do @(posedge i_clk); while (!o_s_axi_bvalid);
    endtask : wr
    // Byte read; rready comes late so the answer must stand
    task automatic rd(input logic [5:0] idx, input logic [33:0] e);
        exp_q.push_back(e);
        i_s_axi_araddr <= {idx, 2'h0};
        i_s_axi_arvalid <= 1'b1;
        do @(posedge i_clk); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        @(posedge i_clk);
        i_s_axi_rready <= 1'b1;
        do @(posedge i_clk); while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b0;
    endtask : rd
    // Oldest note against each read answer
    always @(posedge i_clk) if (o_s_axi_rvalid && i_s_axi_rready) chk({o_s_axi_rresp,
        o_s_axi_rdata}, exp_q.pop_front());
    task automatic print_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // Watchdog
    initial begin
        repeat (5000) @(posedge i_clk);
        fail_count++;
        print_verdict();
    end
    // Counter frozen by halt keeps every value known
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        i_halt <= 1'b1;
        @(posedge i_clk);
        rd(T16CC_IDX_CMP2_HI, ok(8'h80));
        wr(T16CC_IDX_SHD_LO, 8'h5A);
        rd(T16CC_IDX_CNT_HI, ok(8'hFF));
        rd(T16CC_IDX_CNT_LO, ok(8'hFC));
        rd(T16CC_IDX_SHD_LO, ok(8'hFC));
        wr(T16CC_IDX_CTRL_A, 8'h02);
        wr(T16CC_IDX_CTRL_B, 8'h02);
        i_t16cc_pins.cap_pulse(2'h3);
        rd(T16CC_IDX_STATUS, ok(8'h90));
        rd(T16CC_IDX_CAP1_LO, ok(8'hFC));
        rd(T16CC_IDX_CAP2_HI, ok(8'hFF));
        rd(T16CC_IDX_CAP2_LO, ok(8'hFC));
        rd(T16CC_IDX_STATUS, ok(8'h00));
        rnd = 8'($random(seed));
        wr(T16CC_IDX_CMP1_HI, rnd);
        wr(T16CC_IDX_CMP1_LO, ~rnd);
        rd(T16CC_IDX_CMP1_HI, ok(rnd));
        wr(T16CC_IDX_MISC, 8'h01);
        wr(T16CC_IDX_CTRL_A, 8'h21);
        i_halt <= 1'b0;
        repeat (40) @(posedge i_clk);
        i_halt <= 1'b1;
        rd(T16CC_IDX_STATUS, ok(8'h20));
        chk({33'h0, o_timer_irq}, 34'h0);
        wr(T16CC_IDX_MISC, 8'h00);
        @(posedge i_clk);
        chk({33'h0, o_timer_irq}, 34'h1);
        wr(T16CC_IDX_CNT_LO, 8'h00);
        rd(T16CC_IDX_STATUS, ok(8'h00));
        wr(T16CC_IDX_CMP1_HI, 8'h00);
        wr(T16CC_IDX_CMP1_LO, 8'h00);
        wr(T16CC_IDX_CTRL_B, 8'h8D);
        i_halt <= 1'b0;
        i_t16cc_pins.ext_pulses(4);
        repeat (4) @(posedge i_clk);
        rd(T16CC_IDX_CNT_HI, ok(8'h00));
        rd(T16CC_IDX_CNT_LO, ok(8'h00));
        chk({30'h0, o_compare_pin_oe, o_compare_pin}, 34'h5);
        rd(6'h10, {T16CC_RESP_SLVERR, 32'h0});
        print_verdict();
    end
endmodule : tb_top
